//--- shared/eqc_defs.svh
// eqc_defs.svh: offsets, field positions, reset values of the event counter
// assumes a 12-bit apb byte address and 32-bit data words
`ifndef EQC_DEFS_SVH
`define EQC_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define EQC_OFF_TIMER 12'h000
`define EQC_OFF_MODE 12'h004
`define EQC_OFF_CTRL 12'h008
`define EQC_OFF_STAT 12'h00c
// ----------------------------------------
// mode register field positions
// ----------------------------------------
`define EQC_MB_OP_LO 0
`define EQC_MB_OP_HI 1
`define EQC_MB_PULSE 2
`define EQC_MB_DIRPIN 3
`define EQC_MB_RISE 4
`define EQC_MB_FREE 5
`define EQC_MB_SRCOVF 6
`define EQC_MB_OVFSEL 7
`define EQC_MB_TWO 8
`define EQC_MB_X4 9
`define EQC_MODE_W 10
`define EQC_MODE_EVENT 2'h1
// control register field positions
`define EQC_CB_START 0
`define EQC_CB_UP 1
// ----------------------------------------
// counter limits and reset values
// ----------------------------------------
`define EQC_TOP 16'hffff
`define EQC_BOT 16'h0000
`define EQC_RST_CNT 16'h0000
`define EQC_RST_MODE 10'h000
`define EQC_RST_OEN 1'h1
`endif

//--- shared/eqc_pkg.sv
// eqc_pkg: types shared by the event counter modules
// assumes eqc_defs.svh for every number
package eqc_pkg;
   // one synchronised pin: level plus one-cycle edge marks
   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } eqc_edge_t;

   typedef struct packed {
      eqc_edge_t ev;
      eqc_edge_t aux;
   } eqc_pins_t;

   // decoded mode register
   typedef struct packed {
      logic [1:0] opmode;
      logic pulse_en;
      logic dir_pin;
      logic rise_sel;
      logic free_run;
      logic src_ovf;
      logic ovf_sel;
      logic two_phase;
      logic x4;
   } eqc_mode_t;

   // synchroniser stages, bit 1 event pin, bit 0 aux pin
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } eqc_sync_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] reload;
      logic [9:0] mode;
      logic start;
      logic sw_up;
      logic last_up;
      logic aux_out;
      logic oe_n;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } eqc_state_t;
endpackage : eqc_pkg

//--- hdl/eqc_pin_sync.sv
// eqc_pin_sync: two-flop synchronisers and edge marks for both pins
// assumes pins are free-running levels; ce freezes all stages
`timescale 1ns/1ps
module eqc_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic event_in,
   input wire logic aux_in,
   output eqc_pkg::eqc_pins_t pins
);
   eqc_pkg::eqc_sync_t s;
   eqc_pkg::eqc_sync_t next_s;

   // s1 feeds only s2; edges come from s2 against s3
   always_comb begin
      next_s = s;
      if (ce) begin
         next_s.s1 = {event_in, aux_in};
         next_s.s2 = s.s1;
         next_s.s3 = s.s2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // one mark per edge, so each edge counts once
   assign pins.ev = '{s.s2[1], s.s2[1] & ~s.s3[1], ~s.s2[1] & s.s3[1]};
   assign pins.aux = '{s.s2[0], s.s2[0] & ~s.s3[0], ~s.s2[0] & s.s3[0]};
endmodule : eqc_pin_sync

//--- hdl/eqc_quad_dec.sv
// eqc_quad_dec: two-phase direction decode from synchronised pins
// assumes edge marks last one cycle
`timescale 1ns/1ps
module eqc_quad_dec (
   input eqc_pkg::eqc_pins_t pins,
   input wire logic x4,
   output logic up,
   output logic dn
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   // normal: event edges only, while aux is high
   // by four: every edge of both pins, lead decides direction
   always_comb begin
      if (x4) begin
         up = (pins.ev.rise & pins.aux.level) | (pins.ev.fall & ~pins.aux.level) |
              (pins.aux.rise & ~pins.ev.level) | (pins.aux.fall & pins.ev.level);
         dn = (pins.ev.rise & ~pins.aux.level) | (pins.ev.fall & pins.aux.level) |
              (pins.aux.rise & pins.ev.level) | (pins.aux.fall & ~pins.ev.level);
      end else begin
         up = pins.ev.rise & pins.aux.level;
         dn = pins.ev.fall & pins.aux.level;
      end
   end
endmodule : eqc_quad_dec

//--- hdl/eqc_counter.sv
// eqc_counter: one 16-bit timer channel in event counter mode, apb slave
// assumes apb master on pclk, pins asynchronous to pclk, ovf inputs are pulses
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "eqc_defs.svh"
module eqc_counter #(
   parameter int CHAN_IDX = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic event_input_pin,
   input wire logic aux_io_pin_in,
   input wire logic second_group_timer_two_ovf,
   input wire logic neighbour_channel_timer_ovf,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic aux_io_pin_out,
   output logic aux_io_pin_oe_n,
   output logic irq
);
   // ----------------------------------------
   // channel capability
   // ----------------------------------------
   localparam bit TWO_OK = (CHAN_IDX >= 2);
   localparam bit X4_SEL = (CHAN_IDX == 3);
   localparam bit X4_FIX = (CHAN_IDX == 4);

   function automatic eqc_pkg::eqc_mode_t dec_mode(input logic [9:0] m);
      eqc_pkg::eqc_mode_t d;
      d.opmode = m[`EQC_MB_OP_HI:`EQC_MB_OP_LO];
      d.pulse_en = m[`EQC_MB_PULSE];
      d.dir_pin = m[`EQC_MB_DIRPIN];
      d.rise_sel = m[`EQC_MB_RISE];
      d.free_run = m[`EQC_MB_FREE];
      d.src_ovf = m[`EQC_MB_SRCOVF];
      d.ovf_sel = m[`EQC_MB_OVFSEL];
      d.two_phase = m[`EQC_MB_TWO] & TWO_OK;
      d.x4 = X4_FIX | (X4_SEL & m[`EQC_MB_X4]);
      return d;
   endfunction : dec_mode

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction : hit

   eqc_pkg::eqc_state_t s;
   eqc_pkg::eqc_state_t next_s;
   eqc_pkg::eqc_mode_t cfg;
   eqc_pkg::eqc_mode_t next_cfg;
   eqc_pkg::eqc_pins_t pins;
   logic q_up;
   logic q_dn;
   logic run;
   logic src_hit;
   logic dir_up;
   logic step_up;
   logic step_dn;
   logic at_top;
   logic at_bot;
   logic wrap;
   logic setup;
   logic access;
   logic wr_tmr;
   logic mapped;
   logic [31:0] rd_mux;

   // ----------------------------------------
   // pin front end
   // ----------------------------------------
   eqc_pin_sync eqc_pin_sync_inst (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .event_in(event_input_pin),
      .aux_in(aux_io_pin_in),
      .pins(pins)
   );

   eqc_quad_dec eqc_quad_dec_inst (
      .pins(pins),
      .x4(cfg.x4),
      .up(q_up),
      .dn(q_dn)
   );

   // ----------------------------------------
   // count decision
   // ----------------------------------------
   // other modes of the timer are not built, so the counter idles there
   always_comb begin
      cfg = dec_mode(s.mode);
      run = s.start & (cfg.opmode == `EQC_MODE_EVENT);
      src_hit = cfg.src_ovf ?
                (cfg.ovf_sel ? neighbour_channel_timer_ovf : second_group_timer_two_ovf) :
                (cfg.rise_sel ? pins.ev.rise : pins.ev.fall);
      dir_up = cfg.dir_pin ? pins.aux.level : s.sw_up;
      step_up = ce & run & (cfg.two_phase ? q_up : src_hit & dir_up);
      step_dn = ce & run & (cfg.two_phase ? q_dn : src_hit & ~dir_up);
      at_top = s.cnt == `EQC_TOP;
      at_bot = s.cnt == `EQC_BOT;
      wrap = (step_up & at_top) | (step_dn & at_bot);
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // no wait state: read data is sampled in setup, pready is high for access
   always_comb begin
      setup = psel & ~penable;
      access = ce & psel & penable & s.pready;
      wr_tmr = access & pwrite & hit(paddr, `EQC_OFF_TIMER);
      mapped = hit(paddr, `EQC_OFF_TIMER) | hit(paddr, `EQC_OFF_MODE) |
               hit(paddr, `EQC_OFF_CTRL) | hit(paddr, `EQC_OFF_STAT);
      rd_mux = 32'h0000_0000;
      if (hit(paddr, `EQC_OFF_TIMER)) begin
         rd_mux[15:0] = s.cnt;
      end
      if (hit(paddr, `EQC_OFF_MODE)) begin
         rd_mux[9:0] = s.mode;
      end
      if (hit(paddr, `EQC_OFF_CTRL)) begin
         rd_mux[1:0] = {s.sw_up, s.start};
      end
      if (hit(paddr, `EQC_OFF_STAT)) begin
         rd_mux[2:0] = {run, s.last_up, s.aux_out};
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_s = s;
      next_cfg = cfg;
      if (ce) begin
         next_s.irq = wrap;
         if (step_up) begin
            next_s.last_up = 1'b1;
            if (at_top) begin
               next_s.cnt = cfg.free_run ? `EQC_BOT : s.reload;
            end else begin
               next_s.cnt = s.cnt + 16'h0001;
            end
         end
         if (step_dn) begin
            next_s.last_up = 1'b0;
            if (at_bot) begin
               next_s.cnt = cfg.free_run ? `EQC_TOP : s.reload;
            end else begin
               next_s.cnt = s.cnt - 16'h0001;
            end
         end
         if (wrap & cfg.pulse_en) begin
            next_s.aux_out = ~s.aux_out;
         end
         // register writes take effect at the access edge only
         if (access & pwrite) begin
            if (wr_tmr) begin
               next_s.reload = pwdata[15:0];
               if (!s.start) begin
                  next_s.cnt = pwdata[15:0];
               end
            end
            if (hit(paddr, `EQC_OFF_MODE)) begin
               next_s.mode = pwdata[`EQC_MODE_W-1:0];
            end
            if (hit(paddr, `EQC_OFF_CTRL)) begin
               next_s.start = pwdata[`EQC_CB_START];
               next_s.sw_up = pwdata[`EQC_CB_UP];
            end
         end
         // aux drives only as pulse output; otherwise it is left to the port
         next_cfg = dec_mode(next_s.mode);
         next_s.oe_n = ~(next_cfg.pulse_en & ~next_cfg.two_phase & ~next_cfg.dir_pin);
         next_s.pready = setup;
         next_s.pslverr = setup & ~mapped;
         if (setup) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.cnt <= `EQC_RST_CNT;
         s.mode <= `EQC_RST_MODE;
         s.oe_n <= `EQC_RST_OEN;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign aux_io_pin_out = s.aux_out;
   assign aux_io_pin_oe_n = s.oe_n;
   assign irq = s.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic hold_c;
   logic up_rl_c;
   logic free_up_c;
   logic wr_stop_c;
   logic wr_run_c;
   logic rd_tmr_c;
   logic norm_up_c;
   logic dirpin_up_c;
   logic dirpin_dn_c;
   logic dn_rl_c;
   logic x4_up_c;
   logic x4_dn_c;
   always_comb begin
      hold_c = ce & ~run & ~wr_tmr;
      up_rl_c = step_up & at_top & ~cfg.free_run & ~wr_tmr;
      free_up_c = step_up & at_top & cfg.free_run & ~wr_tmr;
      wr_stop_c = wr_tmr & ~s.start;
      wr_run_c = wr_tmr & s.start;
      rd_tmr_c = ce & setup & ~pwrite & hit(paddr, `EQC_OFF_TIMER);
      norm_up_c = ce & run & cfg.two_phase & ~cfg.x4 & pins.ev.rise &
                  pins.aux.level & ~at_top & ~wr_tmr;
      dirpin_up_c = ce & run & ~cfg.two_phase & cfg.dir_pin & src_hit &
                    pins.aux.level & ~at_top & ~wr_tmr;
      dirpin_dn_c = ce & run & ~cfg.two_phase & cfg.dir_pin & src_hit &
                    ~pins.aux.level & ~at_bot & ~wr_tmr;
      dn_rl_c = step_dn & at_bot & ~cfg.free_run & ~wr_tmr;
      // by four, judged from the pins alone: aux rising edge with event steady
      x4_up_c = ce & run & cfg.two_phase & cfg.x4 & pins.aux.rise & ~pins.ev.level &
                ~pins.ev.rise & ~pins.ev.fall & ~at_top & ~wr_tmr;
      x4_dn_c = ce & run & cfg.two_phase & cfg.x4 & pins.aux.rise & pins.ev.level &
                ~pins.ev.rise & ~pins.ev.fall & ~at_bot & ~wr_tmr;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_stop_holds: assert property ($past(hold_c) |-> s.cnt == $past(s.cnt))
      else $error("count moved while stopped");
   a_up_reload: assert property ($past(up_rl_c) |-> s.cnt == $past(s.reload))
      else $error("overflow did not reload");
   a_dn_reload: assert property ($past(dn_rl_c) |-> s.cnt == $past(s.reload))
      else $error("underflow did not reload");
   a_free_wrap: assert property ($past(free_up_c) |-> s.cnt == 16'h0000)
      else $error("free-run overflow did not wrap to zero");
   a_irq_wrap: assert property (s.irq |->
      ($past(s.cnt) == 16'hffff || $past(s.cnt) == 16'h0000))
      else $error("interrupt without wrap");
   a_pulse_toggle: assert property (s.irq && $past(cfg.pulse_en) |->
      s.aux_out != $past(s.aux_out))
      else $error("pulse output did not invert");
   a_wr_stopped: assert property ($past(wr_stop_c) |->
      s.cnt == $past(pwdata[15:0]) && s.reload == $past(pwdata[15:0]))
      else $error("stopped write missed counter or reload");
   a_wr_running: assert property ($past(wr_run_c) |->
      s.reload == $past(pwdata[15:0]))
      else $error("running write missed reload");
   a_read_count: assert property ($past(rd_tmr_c) |->
      s.pready && s.prdata[15:0] == $past(s.cnt))
      else $error("timer read not the count");
   a_norm_up: assert property ($past(norm_up_c) |->
      s.cnt == $past(s.cnt) + 16'h0001)
      else $error("normal two-phase rise did not count up");
   a_dir_pin: assert property ($past(dirpin_up_c) |->
      s.cnt == $past(s.cnt) + 16'h0001)
      else $error("aux high did not select up count");
   a_dir_pin_dn: assert property ($past(dirpin_dn_c) |->
      s.cnt == $past(s.cnt) - 16'h0001)
      else $error("aux low did not select down count");
   a_x4_up: assert property ($past(x4_up_c) |->
      s.cnt == $past(s.cnt) + 16'h0001)
      else $error("by-four aux rise with event low did not count up");
   a_x4_down: assert property ($past(x4_dn_c) |->
      s.cnt == $past(s.cnt) - 16'h0001)
      else $error("by-four aux rise with event high did not count down");
   a_chan_fixed: assert property (!X4_SEL |-> cfg.x4 == X4_FIX)
      else $error("fixed channel processing changed");
endmodule : eqc_counter

//--- dv/eqc_pulse_src.sv
// eqc_pulse_src: behavioural single-phase and two-phase pulse source
// assumes pclk from the bench; the bench calls its tasks by hierarchy
`timescale 1ns/1ps
module eqc_pulse_src (
   input wire logic pclk,
   output logic ev,
   output logic aux
);
   // ----------------
   // pin drive
   // ----------------
   // both pins idle low; aux only reaches the block while its output is off
   initial begin
      ev = 1'b0;
      aux = 1'b0;
   end

   // each level held 4 clocks, twice what the synchroniser needs
   task automatic hold_lvl(input logic e, input logic a);
      @(posedge pclk);
      ev <= e;
      aux <= a;
      repeat (3) @(posedge pclk);
   endtask : hold_lvl

   // full pulses on the event pin, aux left where it is
   task automatic pulse(input int n);
      repeat (n) begin
         hold_lvl(1'b1, aux);
         hold_lvl(1'b0, aux);
      end
   endtask : pulse

   // encoder cycles; fwd means aux leads the event pin
   task automatic quad(input int n, input logic fwd);
      repeat (n) begin
         if (fwd) begin
            hold_lvl(1'b0, 1'b1);
            hold_lvl(1'b1, 1'b1);
            hold_lvl(1'b1, 1'b0);
            hold_lvl(1'b0, 1'b0);
         end else begin
            hold_lvl(1'b1, 1'b0);
            hold_lvl(1'b1, 1'b1);
            hold_lvl(1'b0, 1'b1);
            hold_lvl(1'b0, 1'b0);
         end
      end
   endtask : quad
endmodule : eqc_pulse_src

//--- dv/event_quadrature_counter_tb.sv
// event_quadrature_counter_tb: self-checking bench for one counter channel
// assumes eqc_pulse_src on the pins; apb master and reference model live here
`timescale 1ns/1ps
`include "eqc_defs.svh"
`define CHK(nm, ex, got) chk(nm, 32'(ex), 32'(got))
module event_quadrature_counter_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [1:0] ovf = 2'h0;
   logic [31:0] prdata;
   logic pready, pslverr, aux_out, aux_oe_n, irq, ev, aux_drv, aux_line, err;
   logic [31:0] rdat;
   int error_cnt = 0, tests_run = 0, cycles = 0, irq_seen = 0, k;
   int m_cnt = 0, m_rel = 0, m_wraps = 0, m_aux = 0, m_free = 0, m_pulse = 0, m_run = 0;

   // aux wire: block output wins while its enable is low
   assign aux_line = aux_oe_n ? aux_drv : aux_out;
   always #10 pclk = ~pclk;

   eqc_counter #(.CHAN_IDX(3)) eqc_counter_inst (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .event_input_pin(ev),
      .aux_io_pin_in(aux_line), .second_group_timer_two_ovf(ovf[0]),
      .neighbour_channel_timer_ovf(ovf[1]), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .aux_io_pin_out(aux_out), .aux_io_pin_oe_n(aux_oe_n), .irq(irq));

   eqc_pulse_src eqc_pulse_src_inst (.pclk(pclk), .ev(ev), .aux(aux_drv));

   // ----------------
   // report and watchdog
   // ----------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // irq pulses counted; a hang is cut at a ceiling well above the run
   always @(posedge pclk) begin
      cycles++;
      if (irq === 1'b1) irq_seen++;
      if (cycles == 30000) begin
         error_cnt++;
         complete_run();
      end
   end

   // ----------------
   // apb master and reference model
   // ----------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench watchdog ends a wait for pready
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // settle pins through the synchroniser before sampling the count
   task automatic rd_reg(input logic [11:0] a);
      repeat (4) @(posedge pclk);
      apb(1'b0, a, 32'h00000000);
   endtask : rd_reg

   task automatic cfg(input logic [9:0] md, input logic [1:0] ct);
      apb(1'b1, `EQC_OFF_MODE, 32'(md));
      apb(1'b1, `EQC_OFF_CTRL, 32'(ct));
      m_free = md[5];
      m_pulse = md[2];
      m_run = ct[0];
   endtask : cfg

   // running writes touch only the reload value
   task automatic wr_timer(input logic [15:0] v);
      apb(1'b1, `EQC_OFF_TIMER, 32'(v));
      m_rel = v;
      if (m_run == 0) m_cnt = v;
   endtask : wr_timer

   task automatic step(input int n, input int up);
      repeat (n) begin
         if ((up != 0 && m_cnt == 'hffff) || (up == 0 && m_cnt == 0)) begin
            m_wraps++;
            m_aux ^= m_pulse;
            m_cnt = m_free ? (up ? 0 : 'hffff) : m_rel;
         end else m_cnt = up ? m_cnt + 1 : m_cnt - 1;
      end
   endtask : step

   // ----------------
   // scenarios
   // ----------------
   initial begin
      void'($urandom(57));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd_reg(12'(4 * i));
         `CHK("reset value", 0, rdat);
      end
      rd_reg(12'h010);
      `CHK("unmapped error", 1, err);
      // reload, running write, wrap, pulse output, stop
      for (int d = 1; d >= 0; d--) begin
         k = $urandom % 6 + 1;
         wr_timer(d ? 'hffff - k : k);
         rd_reg(`EQC_OFF_TIMER);
         `CHK("stopped write", m_cnt, rdat);
         cfg(10'h015, {d[0], 1'b1});
         rd_reg(`EQC_OFF_MODE);
         `CHK("mode readback", 'h015, rdat);
         `CHK("aux drive enable", 0, aux_oe_n);
         eqc_pulse_src_inst.pulse(1);
         step(1, d);
         wr_timer(16'($urandom));
         rd_reg(`EQC_OFF_TIMER);
         `CHK("running write", m_cnt, rdat);
         eqc_pulse_src_inst.pulse(k + 1);
         step(k + 1, d);
         rd_reg(`EQC_OFF_TIMER);
         `CHK("count after wrap", m_cnt, rdat);
         `CHK("irq count", m_wraps, irq_seen);
         `CHK("pulse output", m_aux, aux_out);
         cfg(10'h015, 2'h0);
         eqc_pulse_src_inst.pulse(2);
         rd_reg(`EQC_OFF_TIMER);
         `CHK("halted count", m_cnt, rdat);
      end
      // free run in both directions
      for (int d = 1; d >= 0; d--) begin
         wr_timer(d ? 16'hfffe : 16'h0001);
         cfg(10'h031, {d[0], 1'b1});
         eqc_pulse_src_inst.pulse(3);
         step(3, d);
         rd_reg(`EQC_OFF_TIMER);
         `CHK("free run", m_cnt, rdat);
         `CHK("free run irq", m_wraps, irq_seen);
         cfg(10'h031, 2'h0);
      end
      // aux pin picks direction on falling edges; software asks for down
      wr_timer(16'h0100);
      cfg(10'h009, 2'h1);
      eqc_pulse_src_inst.hold_lvl(1'b0, 1'b1);
      eqc_pulse_src_inst.pulse(2);
      step(2, 1);
      eqc_pulse_src_inst.hold_lvl(1'b0, 1'b0);
      eqc_pulse_src_inst.pulse(1);
      step(1, 0);
      rd_reg(`EQC_OFF_TIMER);
      `CHK("direction pin", m_cnt, rdat);
      rd_reg(`EQC_OFF_STAT);
      `CHK("status", 4 + m_aux, rdat);
      cfg(10'h009, 2'h0);
      // overflow sources, the other one pulsing as a decoy
      for (int s = 0; s < 2; s++) begin
         wr_timer(16'h0005);
         cfg(10'(10'h041 | (s << 7)), 2'h3);
         repeat (3) begin
            @(posedge pclk);
            ovf <= 2'(1 << s);
            @(posedge pclk);
            ovf <= 2'(2 >> s);
            @(posedge pclk);
            ovf <= 2'h0;
         end
         step(3, 1);
         rd_reg(`EQC_OFF_TIMER);
         `CHK("overflow source", m_cnt, rdat);
         cfg(10'h041, 2'h0);
      end
      // two-phase, normal and by four, both directions
      for (int x = 0; x < 2; x++) begin
         for (int f = 1; f >= 0; f--) begin
            wr_timer(16'h0010);
            cfg(10'(10'h101 | (x << 9)), 2'h1);
            `CHK("two-phase pin input", 1, aux_oe_n);
            eqc_pulse_src_inst.quad(3, f[0]);
            step(x ? 12 : 3, f);
            rd_reg(`EQC_OFF_TIMER);
            `CHK("two-phase count", m_cnt, rdat);
            cfg(10'h101, 2'h0);
         end
      end
      complete_run();
   end
endmodule : event_quadrature_counter_tb
